// File: core/arith_ext_regs.svh
// constants for the arithmetic extension datapath
`ifndef ARITH_EXT_REGS_SVH
`define ARITH_EXT_REGS_SVH
`define AX_DATA_W 16
`define AX_CNT_W 8
`define AX_CNT_INT_BITS 6
`define AX_STORE_WORDS 256
`define AX_INT_WORD_W 68
`define AX_HOST_BITS 56
`define AX_OWN_BITS 24
`define AX_FLOAT_BITS 8
`define AX_CONST_W 9
`define AX_REG_RESET 16'h0000
`define AX_CNT_RESET 8'h00
`define AX_CC_RESET 4'h0
// extension microword field positions
`define AX_F_HOLD_CLK 0
`define AX_F_LOW_MODE 1
`define AX_F_CNT_LOAD 3
`define AX_F_CNT_STEP 4
`define AX_F_CNT_DOWN 5
`define AX_F_RET_SEL 6
`define AX_F_RET_EN 8
`define AX_F_CC_CLK 9
`define AX_F_BR_SEL 10
`define AX_F_BR_POS 13
`define AX_F_HOST_ROUTE 15
// float microword field positions
`define AX_F_FMODE 0
`define AX_F_FRET_SEL 3
`define AX_F_FRET_EN 5
`define AX_F_FBR_EN 6
`define AX_F_BUS_WRITE 7
`endif

// File: core/arith_ext_pkg.sv
// types for the arithmetic extension datapath
package arith_ext_pkg;
  typedef enum logic [1:0] {
    shift_hold = 2'b00,
    shift_right = 2'b01,
    shift_left = 2'b10,
    shift_load = 2'b11
  } shift_mode_t;
  typedef enum logic [1:0] {
    ret_cond = 2'b00,
    ret_low = 2'b01,
    ret_concat = 2'b10,
    ret_hold = 2'b11
  } int_ret_sel_t;
  typedef enum logic [1:0] {
    fret_high = 2'b00,
    fret_mid = 2'b01,
    fret_const = 2'b10,
    fret_assemble = 2'b11
  } float_ret_sel_t;
  typedef struct packed {
    logic n;
    logic z;
    logic v;
    logic c;
  } cond_codes_t;
endpackage

// File: core/ctrl_word_if.sv
// carries registered extension microword fields from the store unit to the datapath
`timescale 1ns/100ps
interface ctrl_word_if;
  logic [23:0] own_word;
  logic [7:0] float_word;
  modport store (output own_word, output float_word);
  modport datapath (input own_word, input float_word);
endinterface

// File: core/ctrl_store.sv
// integer and float extension control stores with microword registers
`timescale 1ns/100ps
`include "arith_ext_regs.svh"
module ctrl_store #(
  parameter int WORDS = `AX_STORE_WORDS,
  parameter int INT_W = `AX_INT_WORD_W
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // addressing and load
  input wire logic [7:0] addr_i,
  input wire logic word_load_i,
  input wire logic float_active_i,
  // store programming
  input wire logic prog_int_we_i,
  input wire logic prog_float_we_i,
  input wire logic [7:0] prog_addr_i,
  input wire logic [INT_W-1:0] prog_int_data_i,
  input wire logic [7:0] prog_float_data_i,
  // outputs
  output logic [55:0] host_word_o,
  ctrl_word_if.store cw
);
  logic [INT_W-1:0] int_mem [WORDS];
  logic [7:0] float_mem [WORDS];
  logic [INT_W-1:0] int_rd;
  logic [7:0] float_rd;
  logic [55:0] host_q, next_host_q;
  logic [23:0] own_q, next_own_q;
  logic [7:0] float_q, next_float_q;

  always_ff @(posedge clk_i) begin
    if (prog_int_we_i) begin
      int_mem[prog_addr_i] <= prog_int_data_i;
    end
    if (prog_float_we_i) begin
      float_mem[prog_addr_i] <= prog_float_data_i;
    end
  end

  assign int_rd = int_mem[addr_i];
  assign float_rd = float_mem[addr_i];

  // low 44 stored bits are the duplicated host fields; the rest of host word is held low
  always_comb begin
    next_host_q = host_q;
    next_own_q = own_q;
    next_float_q = float_q;
    if (word_load_i) begin
      next_host_q = {12'h000, int_rd[43:0]};
      next_own_q = int_rd[67:44];
      next_float_q = float_active_i ? float_rd : 8'h00;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      host_q <= 56'h00000000000000;
      own_q <= 24'h000000;
      float_q <= 8'h00;
    end else begin
      host_q <= next_host_q;
      own_q <= next_own_q;
      float_q <= next_float_q;
    end
  end

  assign host_word_o = host_q;
  assign cw.own_word = own_q;
  assign cw.float_word = float_q;
endmodule

// File: core/step_counter.sv
// 8-bit up/down step counter with zero detect
`timescale 1ns/100ps
`include "arith_ext_regs.svh"
module step_counter #(
  parameter int W = `AX_CNT_W,
  parameter int INT_BITS = `AX_CNT_INT_BITS
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // control
  input wire logic load_i,
  input wire logic step_i,
  input wire logic down_i,
  input wire logic float_mode_i,
  input wire logic [W-1:0] load_val_i,
  // status
  output logic [W-1:0] count_o,
  output logic zero_o
);
  logic [W-1:0] count, next_count;

  always_comb begin
    next_count = count;
    if (load_i) begin
      next_count = load_val_i;
    end else if (step_i) begin
      next_count = down_i ? count - 1'b1 : count + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      count <= `AX_CNT_RESET;
    end else begin
      count <= next_count;
    end
  end

  assign count_o = count;
  // integer operations only look at the low six bits
  assign zero_o = float_mode_i ? (count == '0) : (count[INT_BITS-1:0] == '0);
endmodule

// File: core/arith_extension_datapath.sv
// extension datapath: holding, shift, counter, codes, return and branch logic
`timescale 1ns/100ps
`include "arith_ext_regs.svh"
module arith_extension_datapath #(
  parameter int DW = `AX_DATA_W,
  parameter logic [8:0] CONST_A = 9'h080,
  parameter logic [8:0] CONST_B = 9'h001,
  parameter logic [8:0] CONST_C = 9'h018,
  parameter logic [8:0] CONST_D = 9'h100
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // host phase pulses
  input wire logic phase_one_pulse_i,
  input wire logic phase_two_pulse_i,
  input wire logic phase_three_pulse_i,
  // host data path
  input wire logic [DW-1:0] host_data_bus_i,
  input wire logic ext_active_i,
  input wire logic float_active_i,
  input wire logic abort_i,
  output logic host_operand_load_en_o,
  // condition code sources
  input wire logic [3:0] cond_in_i,
  input wire logic host_alu_carry_i,
  // control store sequencing and programming
  input wire logic [7:0] micro_pointer_reg_i,
  input wire logic word_load_i,
  input wire logic prog_int_we_i,
  input wire logic prog_float_we_i,
  input wire logic [7:0] prog_addr_i,
  input wire logic [67:0] prog_int_data_i,
  input wire logic [7:0] prog_float_data_i,
  // outputs to host
  output logic [55:0] host_word_o,
  output logic [7:0] next_addr_field_or_o,
  output logic [DW-1:0] return_bus_o,
  output logic return_en_o,
  output logic inhibit_status_clk_o,
  output logic bus_write_cycle_o,
  // visible state
  output logic [7:0] count_o,
  output logic count_zero_o,
  output logic [3:0] local_cond_codes_o
);
  ctrl_word_if cw();
  logic [DW-1:0] input_holding_reg, next_input_holding_reg;
  logic [DW-1:0] low_shift_reg, next_low_shift_reg;
  logic [DW-1:0] high_float_shift_reg, next_high_float_shift_reg;
  logic [DW-1:0] middle_float_shift_reg, next_middle_float_shift_reg;
  arith_ext_pkg::cond_codes_t local_cond_codes, next_local_cond_codes;
  logic [DW-1:0] return_bus, next_return_bus;
  logic return_en, next_return_en;
  logic [7:0] addr_or, next_addr_or;
  logic bus_write, next_bus_write;
  logic inhibit, next_inhibit;
  arith_ext_pkg::shift_mode_t low_mode;
  arith_ext_pkg::int_ret_sel_t ret_sel;
  arith_ext_pkg::float_ret_sel_t fret_sel;
  logic [2:0] fmode;
  logic [2:0] br_sel;
  logic [1:0] br_pos;
  logic shift_phase;
  logic hold_phase;
  logic [8:0] const_val;
  logic [7:0] cnt;
  logic cnt_zero;
  logic branch_int, branch_float, branch_fen;
  logic [DW-1:0] int_mux, float_mux;

  ctrl_store u_store (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .addr_i(micro_pointer_reg_i),
    .word_load_i(word_load_i),
    .float_active_i(float_active_i),
    .prog_int_we_i(prog_int_we_i),
    .prog_float_we_i(prog_float_we_i),
    .prog_addr_i(prog_addr_i),
    .prog_int_data_i(prog_int_data_i),
    .prog_float_data_i(prog_float_data_i),
    .host_word_o(host_word_o),
    .cw(cw.store)
  );

  // field decode of the extension microword
  assign low_mode = arith_ext_pkg::shift_mode_t'(cw.own_word[`AX_F_LOW_MODE +: 2]);
  assign ret_sel = arith_ext_pkg::int_ret_sel_t'(cw.own_word[`AX_F_RET_SEL +: 2]);
  assign br_sel = cw.own_word[`AX_F_BR_SEL +: 3];
  assign br_pos = cw.own_word[`AX_F_BR_POS +: 2];
  assign fmode = cw.float_word[`AX_F_FMODE +: 3];
  assign fret_sel = arith_ext_pkg::float_ret_sel_t'(cw.float_word[`AX_F_FRET_SEL +: 2]);
  assign branch_fen = float_active_i & cw.float_word[`AX_F_FBR_EN];
  assign shift_phase = phase_one_pulse_i | phase_two_pulse_i;
  assign hold_phase = phase_one_pulse_i | phase_three_pulse_i;
  assign host_operand_load_en_o = ~ext_active_i;

  step_counter u_cnt (
    .clk_i(clk_i),
    .sys_rst_i(sys_rst_i),
    .load_i(cw.own_word[`AX_F_CNT_LOAD] & shift_phase),
    .step_i(cw.own_word[`AX_F_CNT_STEP] & shift_phase),
    .down_i(cw.own_word[`AX_F_CNT_DOWN]),
    .float_mode_i(float_active_i),
    .load_val_i(input_holding_reg[7:0]),
    .count_o(cnt),
    .zero_o(cnt_zero)
  );

  // constants generator
  always_comb begin
    case (fmode[1:0])
      2'b00: const_val = CONST_A;
      2'b01: const_val = CONST_B;
      2'b10: const_val = CONST_C;
      default: const_val = CONST_D;
    endcase
  end

  // return multiplexers
  always_comb begin
    case (ret_sel)
      arith_ext_pkg::ret_cond: int_mux = {12'h000, local_cond_codes};
      arith_ext_pkg::ret_low: int_mux = low_shift_reg;
      arith_ext_pkg::ret_concat: int_mux = {input_holding_reg[14:0], low_shift_reg[15]};
      arith_ext_pkg::ret_hold: int_mux = input_holding_reg;
      default: int_mux = input_holding_reg;
    endcase
    case (fret_sel)
      arith_ext_pkg::fret_high: float_mux = high_float_shift_reg;
      arith_ext_pkg::fret_mid: float_mux = middle_float_shift_reg;
      arith_ext_pkg::fret_const: float_mux = {7'h00, const_val};
      arith_ext_pkg::fret_assemble:
        float_mux = {local_cond_codes.n, input_holding_reg[7:0], low_shift_reg[6:0]};
      default: float_mux = high_float_shift_reg;
    endcase
  end

  // branch test multiplexers
  always_comb begin
    case (br_sel)
      3'd0: branch_int = cnt_zero;
      3'd1: branch_int = low_shift_reg[0];
      3'd2: branch_int = low_shift_reg[15];
      3'd3: branch_int = input_holding_reg[15];
      3'd4: branch_int = local_cond_codes.n;
      3'd5: branch_int = local_cond_codes.z;
      3'd6: branch_int = host_alu_carry_i;
      default: branch_int = 1'b0;
    endcase
    case (br_sel)
      3'd0: branch_float = cnt_zero;
      3'd1: branch_float = middle_float_shift_reg[0];
      3'd2: branch_float = low_shift_reg[9];
      3'd3: branch_float = high_float_shift_reg[15];
      3'd4: branch_float = local_cond_codes.n;
      3'd5: branch_float = local_cond_codes.v;
      3'd6: branch_float = host_alu_carry_i;
      default: branch_float = 1'b0;
    endcase
  end

  // datapath registers next state
  always_comb begin
    next_input_holding_reg = input_holding_reg;
    next_low_shift_reg = low_shift_reg;
    next_high_float_shift_reg = high_float_shift_reg;
    next_middle_float_shift_reg = middle_float_shift_reg;
    next_local_cond_codes = local_cond_codes;
    if (ext_active_i && hold_phase && cw.own_word[`AX_F_HOLD_CLK]) begin
      next_input_holding_reg = host_data_bus_i;
    end
    if (shift_phase) begin
      case (low_mode)
        arith_ext_pkg::shift_right:
          next_low_shift_reg = {input_holding_reg[0], low_shift_reg[15:1]};
        arith_ext_pkg::shift_left: next_low_shift_reg = {low_shift_reg[14:0], 1'b0};
        arith_ext_pkg::shift_load: next_low_shift_reg = input_holding_reg;
        default: next_low_shift_reg = low_shift_reg;
      endcase
    end
    // middle register loads in the first phase, high in the second when both load
    if (float_active_i && shift_phase) begin
      case (fmode)
        3'b001: next_high_float_shift_reg = input_holding_reg;
        3'b010: next_middle_float_shift_reg = input_holding_reg;
        3'b011: begin
          if (phase_one_pulse_i) begin
            next_middle_float_shift_reg = input_holding_reg;
          end else begin
            next_high_float_shift_reg = input_holding_reg;
          end
        end
        3'b100: begin
          next_high_float_shift_reg = {1'b0, high_float_shift_reg[15:1]};
          next_middle_float_shift_reg = {high_float_shift_reg[0], middle_float_shift_reg[15:1]};
        end
        3'b101: begin
          next_high_float_shift_reg = {high_float_shift_reg[14:0], middle_float_shift_reg[15]};
          next_middle_float_shift_reg = {middle_float_shift_reg[14:0], host_alu_carry_i};
        end
        3'b110: next_middle_float_shift_reg = {middle_float_shift_reg[14:0], host_alu_carry_i};
        default: next_high_float_shift_reg = high_float_shift_reg;
      endcase
    end
    if (cw.own_word[`AX_F_CC_CLK] && phase_three_pulse_i) begin
      next_local_cond_codes = cond_in_i;
    end
  end

  // outputs to host next state
  always_comb begin
    next_return_en = 1'b0;
    next_return_bus = '0;
    next_inhibit = 1'b0;
    next_addr_or = 8'h00;
    next_bus_write = 1'b0;
    if (ext_active_i && !abort_i) begin
      if (float_active_i && cw.float_word[`AX_F_FRET_EN]) begin
        next_return_en = 1'b1;
        next_return_bus = float_mux;
      end else if (cw.own_word[`AX_F_RET_EN]) begin
        next_return_en = 1'b1;
        next_return_bus = int_mux;
        next_inhibit = (ret_sel == arith_ext_pkg::ret_cond);
      end
      if (branch_fen) begin
        next_addr_or[1] = branch_float;
      end else begin
        next_addr_or[br_pos] = branch_int;
      end
      next_bus_write = float_active_i & cw.float_word[`AX_F_BUS_WRITE];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      input_holding_reg <= `AX_REG_RESET;
      low_shift_reg <= `AX_REG_RESET;
      high_float_shift_reg <= `AX_REG_RESET;
      middle_float_shift_reg <= `AX_REG_RESET;
      local_cond_codes <= `AX_CC_RESET;
      return_bus <= `AX_REG_RESET;
      return_en <= 1'b0;
      inhibit <= 1'b0;
      addr_or <= 8'h00;
      bus_write <= 1'b0;
    end else begin
      input_holding_reg <= next_input_holding_reg;
      low_shift_reg <= next_low_shift_reg;
      high_float_shift_reg <= next_high_float_shift_reg;
      middle_float_shift_reg <= next_middle_float_shift_reg;
      local_cond_codes <= next_local_cond_codes;
      return_bus <= next_return_bus;
      return_en <= next_return_en;
      inhibit <= next_inhibit;
      addr_or <= next_addr_or;
      bus_write <= next_bus_write;
    end
  end

  assign return_bus_o = return_bus;
  assign return_en_o = return_en;
  assign inhibit_status_clk_o = inhibit;
  assign next_addr_field_or_o = addr_or;
  assign bus_write_cycle_o = bus_write;
  assign count_o = cnt;
  assign count_zero_o = cnt_zero;
  assign local_cond_codes_o = local_cond_codes;
endmodule

// File: sim/host_model.sv
// host side model: phase pulse sequencer and next address merge
`timescale 1ns/100ps
module host_model (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // sequencing control
  input wire logic start_i,
  input wire logic [2:0] mask_i,
  input wire logic [7:0] base_addr_i,
  input wire logic [7:0] next_addr_field_or_i,
  // outputs
  output logic phase_one_pulse_o,
  output logic phase_two_pulse_o,
  output logic phase_three_pulse_o,
  output logic [7:0] next_addr_o
);
  logic [2:0] step;
  logic [2:0] next_step;

  // one pass: phase one, two, three, then idle
  always_comb begin
    next_step = 3'h0;
    if (start_i) begin
      next_step = 3'h1;
    end else if (step != 3'h0 && step != 3'h4) begin
      next_step = step + 3'h1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      step <= 3'h0;
    end else begin
      step <= next_step;
    end
  end

  assign phase_one_pulse_o = (step == 3'h1) && mask_i[0];
  assign phase_two_pulse_o = (step == 3'h2) && mask_i[1];
  assign phase_three_pulse_o = (step == 3'h3) && mask_i[2];
  // branch result forces ones into the base address
  assign next_addr_o = base_addr_i | next_addr_field_or_i;
endmodule

// File: sim/arith_ext_chk.sv
// concurrent checks on the extension datapath ports
`timescale 1ns/100ps
module arith_ext_chk (
  // clock and reset
  input wire logic clk_i,
  input wire logic sys_rst_i,
  // inputs watched
  input wire logic phase_three_pulse_i,
  input wire logic ext_active_i,
  input wire logic float_active_i,
  input wire logic abort_i,
  // outputs watched
  input wire logic host_operand_load_en_o,
  input wire logic [55:0] host_word_o,
  input wire logic [7:0] next_addr_field_or_o,
  input wire logic return_en_o,
  input wire logic inhibit_status_clk_o,
  input wire logic bus_write_cycle_o,
  input wire logic [7:0] count_o,
  input wire logic count_zero_o,
  input wire logic [3:0] local_cond_codes_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (sys_rst_i);

  a_operand_route: assert property (host_operand_load_en_o == !ext_active_i)
    else $error("host operand load enable wrong");
  a_host_unused_low: assert property (host_word_o[55:44] == 12'h000)
    else $error("unused host microword bits driven");
  a_abort_no_drive: assert property (abort_i |=> !return_en_o)
    else $error("return driven during abort");
  a_abort_no_inhibit: assert property (abort_i |=> !inhibit_status_clk_o)
    else $error("status inhibit during abort");
  a_abort_no_branch: assert property (abort_i |=> next_addr_field_or_o == 8'h00)
    else $error("branch bits during abort");
  a_write_float_only: assert property (bus_write_cycle_o |->
    $past(float_active_i) && !$past(abort_i))
    else $error("write cycle outside float instruction");
  a_zero_int_six: assert property (!float_active_i |->
    count_zero_o == (count_o[5:0] == 6'h00))
    else $error("integer zero detect wrong");
  a_zero_float_all: assert property (float_active_i |->
    count_zero_o == (count_o == 8'h00))
    else $error("float zero detect wrong");
  a_codes_on_three: assert property (!phase_three_pulse_i |->
    ##1 $stable(local_cond_codes_o))
    else $error("codes changed without phase three");
  a_inhibit_with_ret: assert property (inhibit_status_clk_o |-> return_en_o)
    else $error("status inhibit without return drive");

  c_codes_return: cover property (inhibit_status_clk_o);
  c_bus_write: cover property (bus_write_cycle_o);
  c_abort_block: cover property (abort_i ##1 !return_en_o);
endmodule

// File: sim/tb.sv
// self-checking bench for the extension datapath
`timescale 1ns/100ps
module tb;
  logic clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic ext_active_i = 1'b0, float_active_i = 1'b0, abort_i = 1'b0, word_load_i = 1'b0;
  logic prog_int_we_i = 1'b0, prog_float_we_i = 1'b0, start = 1'b0;
  logic [15:0] host_data_bus_i = 16'h0000;
  logic [3:0] cond_in_i = 4'h0;
  logic [2:0] mask = 3'h7;
  logic [7:0] micro_pointer_reg_i = 8'h00, prog_addr_i = 8'h00, prog_float_data_i = 8'h00;
  logic [67:0] prog_int_data_i = 68'h0;
  logic p1, p2, p3, host_operand_load_en_o, return_en_o, inhibit_status_clk_o;
  logic bus_write_cycle_o, count_zero_o;
  logic [55:0] host_word_o;
  logic [7:0] next_addr_field_or_o, count_o, next_addr;
  logic [15:0] return_bus_o;
  logic [3:0] local_cond_codes_o;
  int errors = 0, tests_run = 0, cycles = 0;
  // entry 17 tests condition v or z onto address bits, entry 18 shifts the float pair right
  logic [23:0] own [19] = '{24'h0001cf, 24'h000140, 24'h000180, 24'h0001c1, 24'h0001c0,
    24'h000142, 24'h000144, 24'h0001c9, 24'h000030, 24'h000010, 24'h000300, 24'h000007,
    24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h000000, 24'h005600, 24'h000000};
  logic [7:0] flw [19] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h03, 8'h28, 8'h20, 8'h38, 8'h30, 8'h80, 8'h40, 8'h2c};

  host_model host (.clk_i, .sys_rst_i, .start_i(start), .mask_i(mask), .base_addr_i(8'h00),
    .next_addr_field_or_i(next_addr_field_or_o), .phase_one_pulse_o(p1),
    .phase_two_pulse_o(p2), .phase_three_pulse_o(p3), .next_addr_o(next_addr));

  arith_extension_datapath dut (.clk_i, .sys_rst_i, .phase_one_pulse_i(p1),
    .phase_two_pulse_i(p2), .phase_three_pulse_i(p3), .host_data_bus_i, .ext_active_i,
    .float_active_i, .abort_i, .host_operand_load_en_o, .cond_in_i,
    .host_alu_carry_i(1'b0), .micro_pointer_reg_i, .word_load_i, .prog_int_we_i,
    .prog_float_we_i, .prog_addr_i, .prog_int_data_i, .prog_float_data_i, .host_word_o,
    .next_addr_field_or_o, .return_bus_o, .return_en_o, .inhibit_status_clk_o,
    .bus_write_cycle_o, .count_o, .count_zero_o, .local_cond_codes_o);

  always #2.5 clk_i = ~clk_i;

  task automatic print_verdict;
    if (errors == 0 && tests_run > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  task automatic chk(input logic [55:0] got, input logic [55:0] exp);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  // load a microword, then run one phase pass; ctl is {abort, float, ext}
  task automatic exec(input int a, input logic [15:0] bus, input logic [2:0] m,
    input logic [2:0] ctl);
    @(posedge clk_i);
    micro_pointer_reg_i <= 8'(a);
    word_load_i <= 1'b1;
    host_data_bus_i <= bus;
    cond_in_i <= bus[3:0];
    mask <= m;
    {abort_i, float_active_i, ext_active_i} <= ctl;
    @(posedge clk_i);
    word_load_i <= 1'b0;
    start <= 1'b1;
    @(posedge clk_i);
    start <= 1'b0;
    repeat (7) @(posedge clk_i);
    #1;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 3000) begin
      errors++;
      print_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    for (int i = 0; i < 19; i++) begin
      @(posedge clk_i);
      prog_addr_i <= 8'(i);
      prog_int_data_i <= {own[i], 36'h5a5a5a5a5, 8'(i)};
      prog_float_data_i <= flw[i];
      prog_int_we_i <= 1'b1;
      prog_float_we_i <= 1'b1;
    end
    @(posedge clk_i);
    prog_int_we_i <= 1'b0;
    prog_float_we_i <= 1'b0;
    exec(0, 16'ha5c3, 3'h7, 3'h1);
    chk(return_bus_o, 16'ha5c3);
    chk(count_o, 8'hc3);
    chk(host_word_o, {12'h000, 36'h5a5a5a5a5, 8'h00});
    chk(return_en_o, 1'b1);
    exec(1, 16'h1234, 3'h7, 3'h1);
    chk(return_bus_o, 16'ha5c3);
    exec(2, 16'h1234, 3'h7, 3'h1);
    chk(return_bus_o, 16'h4b87);
    exec(3, 16'h1234, 3'h7, 3'h0);
    exec(4, 16'h1234, 3'h7, 3'h1);
    chk(return_bus_o, 16'ha5c3);
    exec(5, 16'h1234, 3'h1, 3'h1);
    chk(return_bus_o[14:0], 15'h52e1);
    exec(6, 16'h1234, 3'h1, 3'h1);
    chk(return_bus_o[15:1], 15'h52e1);
    exec(7, 16'h0001, 3'h7, 3'h1);
    chk(count_o, 8'h01);
    exec(8, 16'h0001, 3'h1, 3'h1);
    chk({count_o, count_zero_o}, 9'h001);
    exec(8, 16'h0001, 3'h1, 3'h1);
    chk(count_o, 8'hff);
    exec(9, 16'h0001, 3'h1, 3'h1);
    chk(count_o, 8'h00);
    exec(7, 16'h0040, 3'h7, 3'h1);
    chk(count_zero_o, 1'b1);
    chk(next_addr, 8'h01);
    exec(4, 16'h0040, 3'h7, 3'h3);
    chk(count_zero_o, 1'b0);
    chk(next_addr, 8'h00);
    exec(10, 16'h000a, 3'h7, 3'h1);
    chk(local_cond_codes_o, 4'ha);
    chk({return_bus_o[3:0], inhibit_status_clk_o}, 5'h15);
    exec(10, 16'h0005, 3'h7, 3'h5);
    chk(local_cond_codes_o, 4'h5);
    chk({return_en_o, inhibit_status_clk_o}, 2'b00);
    exec(11, 16'h3c5a, 3'h7, 3'h3);
    exec(12, 16'h3c5a, 3'h7, 3'h3);
    chk(return_bus_o, 16'h0040);
    exec(13, 16'h3c5a, 3'h7, 3'h3);
    chk(return_bus_o, 16'h3c5a);
    exec(14, 16'h3c5a, 3'h7, 3'h3);
    chk(return_bus_o, 16'h2d5a);
    exec(15, 16'h3c5a, 3'h7, 3'h3);
    chk({return_en_o, return_bus_o[15:9]}, 8'h80);
    exec(16, 16'h3c5a, 3'h7, 3'h3);
    chk(bus_write_cycle_o, 1'b1);
    exec(16, 16'h3c5a, 3'h7, 3'h1);
    chk(bus_write_cycle_o, 1'b0);
    exec(12, 16'h3c5a, 3'h7, 3'h1);
    chk(return_en_o, 1'b0);
    exec(18, 16'h3c5a, 3'h1, 3'h3);
    chk(return_bus_o, 16'h0020);
    exec(17, 16'h3c5a, 3'h7, 3'h3);
    chk(next_addr, 8'h02);
    exec(17, 16'h3c55, 3'h7, 3'h1);
    chk(next_addr, 8'h04);
    print_verdict();
  end
endmodule

bind arith_extension_datapath arith_ext_chk chk (.clk_i, .sys_rst_i, .phase_three_pulse_i,
  .ext_active_i, .float_active_i, .abort_i, .host_operand_load_en_o, .host_word_o,
  .next_addr_field_or_o, .return_en_o, .inhibit_status_clk_o, .bus_write_cycle_o,
  .count_o, .count_zero_o, .local_cond_codes_o);
